// file: sia_core.sv
// Strain indicator post-processing: calibration, tare, peak, alarms, analog output
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps

//Function
// RULE1: Two alarm channels, each with own mode, thresholds, polarity and relay.
// RULE2: Range mode energizes relay between low and high; low polarity inverts.
// RULE3: Above mode drives selected relay state when value exceeds high threshold.
// RULE4: Below mode drives selected relay state when value is under low threshold.
// RULE5: Voltage output maps minimum value to range bottom, maximum to top.
// RULE6: Current output maps linearly; four-to-twenty range gives 4mA to 20mA.
// RULE7: Output scaling minimum and maximum are set apart from sensor full scale.
// RULE8: Measured value is published for holding register 40001.
// RULE9: Node id, link type and baud rate are applied once saved.
// RULE10: Calibrated value is multiplied by the configured factor.
// RULE11: Samples are taken at a selectable rate.
// RULE12: Display refreshes at its own selectable rate.
// RULE13: Peak hold shows greatest value since activation.
// RULE14: Peak and zero come from software or remote terminals.
// RULE15: Remote peak shows peak while held, actual value once released.
// RULE16: Remote inputs are grounded momentary contacts, active low.
// RULE17: Each remote zero press tares the displayed value to zero.
// RULE18: Unloaded zero command stores the present reading as zero reference.
// RULE19: Saving known load derives span gain from zero and loaded readings.
// RULE20: Compression sensor is unipolar, tension sensor is bipolar.
// RULE21: Torque direction selects clockwise or counter-clockwise sign.
// RULE22: Sensitivity and full scale scale raw input; unit and point shown.
// RULE23: Bridge excitation selectable between 5V and 10V.
// RULE24: Remote inputs are synchronised and debounced; one press, one action.
// RULE25: Alarms re-evaluate on every processed sample after all scaling.
module sia_core import sia_pkg::*; #(
  parameter int unsigned MS_CYC = MS_CYCLES,
  parameter int unsigned DEB_CYC = DEB_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata,
  output logic sample_req,
  input wire logic adc_valid,
  input wire logic [23:0] adc_data,
  input wire logic remote_zero_n,
  input wire logic remote_peak_n,
  output logic [1:0] relay_on,
  output logic [15:0] ao_value,
  output logic ao_is_current,
  output logic exc_10v,
  output logic [31:0] display_value,
  output logic display_strobe,
  output logic [2:0] display_dp,
  output logic [3:0] display_unit,
  output logic peak_active,
  output logic [15:0] hold_reg_addr,
  output logic [15:0] hold_reg_hi,
  output logic [15:0] hold_reg_lo,
  output logic [7:0] node_id,
  output logic [1:0] link_type,
  output logic [2:0] baud_sel
);

  typedef struct packed {
    logic [1:0] sy1;
    logic [1:0] sy2;
    logic [1:0] sy3;
    logic [1:0] stb;
    logic [1:0][31:0] deb;
    logic [31:0] ms_cnt;
    logic [7:0] smp_ms;
    logic [7:0] dsp_ms;
    logic smp_req;
    logic raw_new;
    logic proc_new;
    logic disp_stb;
    logic [31:0] ctrl;
    logic [31:0] sens;
    logic [31:0] fs;
    logic [31:0] known;
    logic [31:0] mult;
    logic [31:0] ao_min;
    logic [31:0] ao_max;
    logic [12:0] comm_sh;
    logic [1:0][2:0] alm_cfg;
    logic [1:0][31:0] alm_lo;
    logic [1:0][31:0] alm_hi;
    logic [31:0] raw;
    logic [31:0] zero_ref;
    logic [31:0] sens_gain;
    logic [31:0] span_gain;
    logic [31:0] ao_gain;
    logic [31:0] gross;
    logic [31:0] tare;
    logic [31:0] value;
    logic [31:0] peak;
    logic peak_on;
    logic [31:0] disp;
    logic [1:0] relay;
    logic [15:0] ao;
    logic ao_cur;
    logic [7:0] node;
    logic [1:0] link;
    logic [2:0] baud;
    logic [15:0] hold_hi;
    logic [15:0] hold_lo;
    logic [31:0] rdata;
    sia_div_state_type dst;
    logic [1:0] dsel;
    logic dneg;
    logic [5:0] dcnt;
    logic [47:0] dq;
    logic [31:0] drem;
    logic [31:0] dden;
  } sia_state_type;

  sia_state_type q;
  sia_state_type n;

  // Signed fixed-point product, shifted back by sh fraction bits
  function automatic logic [31:0] mulq(input logic [31:0] a, input logic [31:0] b, input int sh);
    logic signed [63:0] p;
    p = 64'($signed(a)) * 64'($signed(b));
    return p[sh +: 32];
  endfunction

  function automatic logic [31:0] mag(input logic [31:0] a);
    return a[31] ? 32'(-a) : a;
  endfunction

  function automatic logic alm_eval(input logic [2:0] cfg, input logic [31:0] v,
                                    input logic [31:0] lo, input logic [31:0] hi);
    logic hit;
    hit = 1'b0;
    case (sia_alm_mode_type'(cfg[1:0]))
      SIA_ALM_RANGE: hit = $signed(v) >= $signed(lo) && $signed(v) <= $signed(hi); // RULE2
      SIA_ALM_ABOVE: hit = $signed(v) > $signed(hi); // RULE3
      SIA_ALM_BELOW: hit = $signed(v) < $signed(lo); // RULE4
      default: return 1'b0;
    endcase
    // Polarity high energizes on hit, low energizes off it
    return cfg[2] ? hit : ~hit;
  endfunction

  always_comb begin
    logic tick;
    logic zero_evt;
    logic tare_evt;
    logic [31:0] v1;
    logic [31:0] v2;
    logic [31:0] lo16;
    logic [31:0] hi16;
    logic [31:0] t;
    logic [32:0] r;
    logic [47:0] num;
    logic [31:0] den;
    logic [1:0] sel;
    logic neg;
    logic go;
    logic [31:0] res;
    tick = 1'b0;
    zero_evt = 1'b0;
    tare_evt = 1'b0;
    v1 = '0;
    v2 = '0;
    lo16 = '0;
    hi16 = '0;
    t = '0;
    r = '0;
    num = '0;
    den = '0;
    sel = DIV_SENS;
    neg = 1'b0;
    go = 1'b0;
    res = '0;
    n = q;
    if (clk_en) begin
      n.smp_req = 1'b0;
      n.raw_new = 1'b0;
      n.proc_new = 1'b0;
      n.disp_stb = 1'b0;

      // Remote contacts: three stages, then a hold-off before a change is accepted
      n.sy1 = {remote_peak_n, remote_zero_n}; // RULE16
      n.sy2 = q.sy1;
      n.sy3 = q.sy2;
      for (int i = 0; i < 2; i++) begin
        if (q.sy2[i] == q.sy3[i] && q.sy3[i] != q.stb[i]) begin
          if (q.deb[i] >= DEB_CYC - 1) begin
            n.stb[i] = q.sy3[i]; // RULE24
            n.deb[i] = '0;
          end else begin
            n.deb[i] = q.deb[i] + 32'h0000_0001;
          end
        end else begin
          n.deb[i] = '0;
        end
      end
      zero_evt = q.stb[0] & ~n.stb[0]; // RULE17

      // Millisecond base and the two rate dividers
      tick = q.ms_cnt >= MS_CYC - 1;
      n.ms_cnt = tick ? '0 : q.ms_cnt + 32'h0000_0001;
      if (tick) begin
        if (q.smp_ms + 8'h01 >= sia_rate_ms(q.ctrl[CTL_SRATE_LSB +: 3])) begin
          n.smp_ms = '0;
          n.smp_req = 1'b1; // RULE11
        end else begin
          n.smp_ms = q.smp_ms + 8'h01;
        end
        if (q.dsp_ms + 8'h01 >= sia_rate_ms(q.ctrl[CTL_DRATE_LSB +: 3])) begin
          n.dsp_ms = '0;
          n.disp = q.peak_on ? q.peak : q.value; // RULE12 RULE13
          n.disp_stb = 1'b1;
        end else begin
          n.dsp_ms = q.dsp_ms + 8'h01;
        end
      end
      if (adc_valid) begin
        n.raw = {{8{adc_data[23]}}, adc_data};
        n.raw_new = 1'b1;
      end

      // Sample chain: zero, sensor gain, span, sign, factor
      v1 = mulq(q.raw - q.zero_ref, q.sens_gain, 16); // RULE22
      v2 = mulq(v1, q.span_gain, 16);
      if (sia_sensor_type'(q.ctrl[CTL_TYPE_LSB +: 2]) == SIA_TORQUE && q.ctrl[CTL_CCW_BIT]) begin
        v2 = 32'(-v2); // RULE21
      end
      if (sia_sensor_type'(q.ctrl[CTL_TYPE_LSB +: 2]) == SIA_COMPRESSION && v2[31]) begin
        v2 = '0; // RULE20
      end
      if (q.raw_new) begin
        n.gross = mulq(v2, q.mult, 8); // RULE10
        n.proc_new = 1'b1;
      end

      // Register writes
      if (reg_we) begin
        case (reg_addr)
          OFS_CTRL: n.ctrl = reg_wdata;
          OFS_SENS: n.sens = reg_wdata;
          OFS_FSCALE: n.fs = reg_wdata;
          OFS_KNOWN: n.known = reg_wdata;
          OFS_MULT: n.mult = reg_wdata;
          OFS_AO_MIN: n.ao_min = reg_wdata; // RULE7
          OFS_AO_MAX: n.ao_max = reg_wdata; // RULE7
          OFS_COMM: n.comm_sh = reg_wdata[12:0];
          OFS_CMD: begin
            if (reg_wdata[CMD_CAL_ZERO]) begin
              n.zero_ref = q.raw; // RULE18
            end
            tare_evt = reg_wdata[CMD_TARE]; // RULE14
            if (reg_wdata[CMD_COMM_SAVE]) begin
              n.node = q.comm_sh[7:0]; // RULE9
              n.link = q.comm_sh[9:8];
              n.baud = q.comm_sh[12:10];
            end
            if (reg_wdata[CMD_SENS_SAVE]) begin
              go = 1'b1;
              sel = DIV_SENS;
              num = {mag(q.fs), 16'h0000};
              den = mag(q.sens);
              neg = q.fs[31] ^ q.sens[31];
            end else if (reg_wdata[CMD_SPAN_SAVE]) begin
              go = 1'b1;
              sel = DIV_SPAN;
              num = {mag(q.known), 16'h0000}; // RULE19
              den = mag(v1);
              neg = q.known[31] ^ v1[31];
            end else if (reg_wdata[CMD_AO_SAVE]) begin
              go = 1'b1;
              sel = DIV_AO;
              t = 32'(signed'(sia_ao_hi(q.ctrl[CTL_AOMODE_LSB +: 3])))
                - 32'(signed'(sia_ao_lo(q.ctrl[CTL_AOMODE_LSB +: 3])));
              num = {t, 16'h0000};
              den = mag(q.ao_max - q.ao_min);
              neg = den != '0 && q.ao_max[31] ^ q.ao_min[31] ^ (q.ao_max - q.ao_min) != q.ao_max - q.ao_min
                ? 1'b0 : $signed(q.ao_max) < $signed(q.ao_min);
            end
          end
          default: begin
            for (int c = 0; c < 2; c++) begin
              if (reg_addr == OFS_ALM_BASE + 8'(c) * OFS_ALM_STRIDE) begin
                n.alm_cfg[c] = reg_wdata[2:0]; // RULE1
              end
              if (reg_addr == OFS_ALM_BASE + 8'(c) * OFS_ALM_STRIDE + OFS_ALM_LO) begin
                n.alm_lo[c] = reg_wdata;
              end
              if (reg_addr == OFS_ALM_BASE + 8'(c) * OFS_ALM_STRIDE + OFS_ALM_HI) begin
                n.alm_hi[c] = reg_wdata;
              end
            end
          end
        endcase
      end

      // Tare from software or the remote zero contact
      if (tare_evt || zero_evt) begin
        n.tare = n.gross; // RULE17
        n.proc_new = 1'b1;
      end
      n.value = n.gross - n.tare;

      // Divider for the saved gains; a zero divisor leaves the old gain
      case (q.dst)
        SIA_DIV_IDLE: begin
          if (go && den != '0) begin
            n.dst = SIA_DIV_RUN;
            n.dsel = sel;
            n.dneg = neg;
            n.dq = num;
            n.drem = '0;
            n.dden = den;
            n.dcnt = '0;
          end
        end
        SIA_DIV_RUN: begin
          r = {q.drem, q.dq[47]};
          if (r >= {1'b0, q.dden}) begin
            r = r - {1'b0, q.dden};
          end
          n.dq = {q.dq[46:0], r != {q.drem, q.dq[47]}};
          n.drem = r[31:0];
          n.dcnt = q.dcnt + 6'h01;
          if (q.dcnt == DIV_LAST) begin
            n.dst = SIA_DIV_IDLE;
            res = q.dneg ? 32'(-n.dq[31:0]) : n.dq[31:0];
            case (q.dsel)
              DIV_SENS: n.sens_gain = res; // RULE22
              DIV_SPAN: n.span_gain = res; // RULE19
              default: n.ao_gain = res;
            endcase
          end
        end
        default: n.dst = SIA_DIV_IDLE;
      endcase

      // Alarms and analog output follow every processed value
      if (q.proc_new) begin
        for (int c = 0; c < 2; c++) begin
          n.relay[c] = alm_eval(q.alm_cfg[c], q.value, q.alm_lo[c], q.alm_hi[c]); // RULE25 RULE1
        end
        lo16 = 32'(signed'(sia_ao_lo(q.ctrl[CTL_AOMODE_LSB +: 3])));
        hi16 = 32'(signed'(sia_ao_hi(q.ctrl[CTL_AOMODE_LSB +: 3])));
        t = lo16 + mulq(q.value - q.ao_min, q.ao_gain, 16); // RULE5 RULE6
        // Clamp so an out-of-range value never drives past the range ends
        if ($signed(t) < $signed(lo16)) begin
          t = lo16;
        end
        if ($signed(t) > $signed(hi16)) begin
          t = hi16;
        end
        n.ao = t[15:0];
        n.ao_cur = q.ctrl[CTL_AOMODE_LSB +: 3] >= 3'h3; // RULE6
        n.hold_hi = q.value[31:16]; // RULE8
        n.hold_lo = q.value[15:0];
      end

      // Peak follows the value while inactive, so it starts at the present value
      n.peak_on = q.ctrl[CTL_PEAK_BIT] | ~q.stb[1]; // RULE14 RULE15
      if (!q.peak_on || $signed(q.value) > $signed(q.peak)) begin
        n.peak = q.value; // RULE13
      end

      // Read port, data one cycle after the strobe
      n.rdata = '0;
      if (reg_re) begin
        case (reg_addr)
          OFS_CTRL: n.rdata = q.ctrl;
          OFS_SENS: n.rdata = q.sens;
          OFS_FSCALE: n.rdata = q.fs;
          OFS_KNOWN: n.rdata = q.known;
          OFS_MULT: n.rdata = q.mult;
          OFS_AO_MIN: n.rdata = q.ao_min;
          OFS_AO_MAX: n.rdata = q.ao_max;
          OFS_COMM: n.rdata = {19'h0, q.comm_sh};
          OFS_STATUS: n.rdata = {26'h0, q.dst == SIA_DIV_RUN, q.peak_on, ~q.stb, q.relay};
          OFS_VALUE: n.rdata = q.value;
          OFS_DISP: n.rdata = q.disp;
          OFS_PEAK: n.rdata = q.peak;
          OFS_ZERO: n.rdata = q.zero_ref;
          OFS_GAIN: n.rdata = q.span_gain;
          default: begin
            for (int c = 0; c < 2; c++) begin
              if (reg_addr == OFS_ALM_BASE + 8'(c) * OFS_ALM_STRIDE) begin
                n.rdata = {29'h0, q.alm_cfg[c]};
              end
              if (reg_addr == OFS_ALM_BASE + 8'(c) * OFS_ALM_STRIDE + OFS_ALM_LO) begin
                n.rdata = q.alm_lo[c];
              end
              if (reg_addr == OFS_ALM_BASE + 8'(c) * OFS_ALM_STRIDE + OFS_ALM_HI) begin
                n.rdata = q.alm_hi[c];
              end
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q <= '0;
      q.sy1 <= 2'h3;
      q.sy2 <= 2'h3;
      q.sy3 <= 2'h3;
      q.stb <= 2'h3;
      q.mult <= RST_MULT;
      q.sens_gain <= RST_GAIN;
      q.span_gain <= RST_GAIN;
      q.ao_gain <= RST_GAIN;
      q.ao_max <= RST_AO_MAX;
      q.dst <= SIA_DIV_IDLE;
    end else begin
      q <= n;
    end
  end

  assign reg_rdata = q.rdata;
  assign sample_req = q.smp_req;
  assign relay_on = q.relay;
  assign ao_value = q.ao;
  assign ao_is_current = q.ao_cur;
  assign exc_10v = q.ctrl[CTL_EXC_BIT]; // RULE23
  assign display_value = q.disp;
  assign display_strobe = q.disp_stb;
  assign display_dp = q.ctrl[CTL_DP_LSB +: 3]; // RULE22
  assign display_unit = q.ctrl[CTL_UNIT_LSB +: 4];
  assign peak_active = q.peak_on;
  assign hold_reg_addr = HOLD_REG_ADDR; // RULE8
  assign hold_reg_hi = q.hold_hi;
  assign hold_reg_lo = q.hold_lo;
  assign node_id = q.node;
  assign link_type = q.link;
  assign baud_sel = q.baud;

endmodule // sia_core

// file: sia_pkg.sv
// Constants, types and helper functions for the strain indicator core
package sia_pkg;

  // Clock and time base
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned MS_CYCLES = CLK_HZ / MS_PER_S;
  localparam int unsigned DEB_TIME_MS = 10;
  localparam int unsigned DEB_CYCLES = DEB_TIME_MS * MS_CYCLES;

  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_SENS = 8'h08;
  localparam logic [7:0] OFS_FSCALE = 8'h0c;
  localparam logic [7:0] OFS_KNOWN = 8'h10;
  localparam logic [7:0] OFS_MULT = 8'h14;
  localparam logic [7:0] OFS_AO_MIN = 8'h18;
  localparam logic [7:0] OFS_AO_MAX = 8'h1c;
  localparam logic [7:0] OFS_ALM_BASE = 8'h20;
  localparam logic [7:0] OFS_ALM_STRIDE = 8'h0c;
  localparam logic [7:0] OFS_ALM_LO = 8'h04;
  localparam logic [7:0] OFS_ALM_HI = 8'h08;
  localparam logic [7:0] OFS_COMM = 8'h38;
  localparam logic [7:0] OFS_STATUS = 8'h3c;
  localparam logic [7:0] OFS_VALUE = 8'h40;
  localparam logic [7:0] OFS_DISP = 8'h44;
  localparam logic [7:0] OFS_PEAK = 8'h48;
  localparam logic [7:0] OFS_ZERO = 8'h4c;
  localparam logic [7:0] OFS_GAIN = 8'h50;

  // Control register fields
  localparam int CTL_TYPE_LSB = 0;
  localparam int CTL_CCW_BIT = 2;
  localparam int CTL_EXC_BIT = 3;
  localparam int CTL_SRATE_LSB = 4;
  localparam int CTL_DRATE_LSB = 7;
  localparam int CTL_AOMODE_LSB = 10;
  localparam int CTL_DP_LSB = 13;
  localparam int CTL_UNIT_LSB = 16;
  localparam int CTL_PEAK_BIT = 20;

  // Command register bits
  localparam int CMD_CAL_ZERO = 0;
  localparam int CMD_SPAN_SAVE = 1;
  localparam int CMD_TARE = 2;
  localparam int CMD_SENS_SAVE = 3;
  localparam int CMD_AO_SAVE = 4;
  localparam int CMD_COMM_SAVE = 5;

  // Reset values
  localparam logic [31:0] RST_GAIN = 32'h0001_0000;
  localparam logic [31:0] RST_MULT = 32'h0000_0100;
  localparam logic [31:0] RST_AO_MAX = 32'h0000_2710;
  // Holding register 40001
  localparam logic [15:0] HOLD_REG_ADDR = 16'h9c41;

  localparam logic [1:0] DIV_SENS = 2'h0;
  localparam logic [1:0] DIV_SPAN = 2'h1;
  localparam logic [1:0] DIV_AO = 2'h2;
  localparam logic [5:0] DIV_LAST = 6'h2f;

  typedef enum logic [1:0] {
    SIA_COMPRESSION = 2'h0,
    SIA_TENSION = 2'h1,
    SIA_TORQUE = 2'h2
  } sia_sensor_type;

  typedef enum logic [1:0] {
    SIA_ALM_OFF = 2'h0,
    SIA_ALM_RANGE = 2'h1,
    SIA_ALM_ABOVE = 2'h2,
    SIA_ALM_BELOW = 2'h3
  } sia_alm_mode_type;

  typedef enum logic [1:0] {
    SIA_DIV_IDLE = 2'b01,
    SIA_DIV_RUN = 2'b10
  } sia_div_state_type;

  // Analog output endpoints, millivolts or microamps
  function automatic logic [15:0] sia_ao_lo(input logic [2:0] m);
    case (m)
      3'h2: return 16'hd8f0;
      3'h4: return 16'h0fa0;
      3'h5: return 16'h07d0;
      default: return 16'h0000;
    endcase
  endfunction

  function automatic logic [15:0] sia_ao_hi(input logic [2:0] m);
    case (m)
      3'h0: return 16'h1388;
      3'h3: return 16'h4e20;
      3'h4: return 16'h4e20;
      3'h5: return 16'h5dc0;
      default: return 16'h2710;
    endcase
  endfunction

  // Period in milliseconds for a rate selection
  function automatic logic [7:0] sia_rate_ms(input logic [2:0] s);
    case (s)
      3'h0: return 8'h01;
      3'h1: return 8'h02;
      3'h2: return 8'h05;
      3'h3: return 8'h0a;
      3'h4: return 8'h14;
      3'h5: return 8'h32;
      3'h6: return 8'h64;
      default: return 8'hc8;
    endcase
  endfunction

endpackage

// file: sia_core_sva.sv
// Port-level assertion checker for the strain indicator core
`timescale 1ns/10ps
module sia_core_sva import sia_pkg::*; #(
  parameter int unsigned DEB_CYC = DEB_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  input wire logic [31:0] reg_rdata,
  input wire logic sample_req,
  input wire logic remote_peak_n,
  input wire logic [1:0] relay_on,
  input wire logic exc_10v,
  input wire logic [31:0] display_value,
  input wire logic display_strobe,
  input wire logic [2:0] display_dp,
  input wire logic peak_active,
  input wire logic [15:0] hold_reg_addr,
  input wire logic [7:0] node_id
);
  // Sync stages plus debounce, with slack for the output flop
  localparam int PK_WAIT = DEB_CYC + 8;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_rdata_idle: assert property (!$past(reg_re) |-> reg_rdata == 32'h0)
    else $error("read data outside answer cycle");
  a_status_read: assert property (reg_re && reg_addr == OFS_STATUS |=>
    reg_rdata[1:0] == $past(relay_on) && reg_rdata[4] == $past(peak_active))
    else $error("status read disagrees with outputs");
  a_hold_addr: assert property (hold_reg_addr == HOLD_REG_ADDR)
    else $error("holding register address wrong");
  a_disp_pulse: assert property (display_strobe |=> !display_strobe)
    else $error("display strobe longer than one cycle");
  a_disp_hold: assert property ($changed(display_value) |-> display_strobe)
    else $error("display changed without strobe");
  a_sample_gap: assert property (sample_req |=> !sample_req [*8])
    else $error("sample requests too close");
  a_peak_press: assert property (!remote_peak_n [*8] |-> ##[0:PK_WAIT] peak_active)
    else $error("held peak pin not accepted");
  a_exc_write: assert property ($changed(exc_10v) |-> $past(reg_we) &&
    $past(reg_addr) == OFS_CTRL && exc_10v == $past(reg_wdata[3]))
    else $error("excitation changed without control write");
  a_dp_hold: assert property (!($past(reg_we) && $past(reg_addr) == OFS_CTRL) |-> $stable(display_dp))
    else $error("decimal point changed without control write");
  a_comm_save: assert property ($changed(node_id) |-> $past(reg_we) &&
    $past(reg_addr) == OFS_CMD && $past(reg_wdata[5]))
    else $error("node id changed without save");
  c_both_relays: cover property (relay_on == 2'h3);
  c_peak_on: cover property ($rose(peak_active));
  c_peak_disp: cover property (display_strobe && peak_active);
endmodule // sia_core_sva

bind sia_core sia_core_sva #(.DEB_CYC(DEB_CYC)) i_sva (.clk(clk), .reset(reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .sample_req(sample_req),
  .remote_peak_n(remote_peak_n), .relay_on(relay_on), .exc_10v(exc_10v), .display_value(display_value),
  .display_strobe(display_strobe), .display_dp(display_dp), .peak_active(peak_active),
  .hold_reg_addr(hold_reg_addr), .node_id(node_id));

// file: sia_sensor_model.sv
// Bridge converter and remote pushbutton model
`timescale 1ns/10ps
module sia_sensor_model #(
  parameter int LAT = 3
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic sample_req,
  input wire logic [23:0] raw,
  input wire logic zero_press,
  input wire logic peak_press,
  output logic adc_valid,
  output logic [23:0] adc_data,
  output logic remote_zero_n,
  output logic remote_peak_n
);
  logic [3:0] cnt_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_q <= 4'h0;
      adc_valid <= 1'b0;
      adc_data <= 24'h0;
    end else begin
      adc_valid <= 1'b0;
      // Stale data is scrambled so nobody can rely on it
      adc_data <= ~adc_data;
      if (sample_req) cnt_q <= 4'(LAT);
      else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
      if (cnt_q == 4'h1) begin
        adc_valid <= 1'b1;
        adc_data <= raw;
      end
    end
  end
  // Contacts pull the pins to ground; pull-ups hold them high otherwise
  assign remote_zero_n = !zero_press;
  assign remote_peak_n = !peak_press;
endmodule // sia_sensor_model

// file: testbench.sv
// Self-checking bench for the strain indicator core
`timescale 1ns/10ps
module testbench import sia_pkg::*;;
  logic clk = 1'b0, reset = 1'b1, reg_we = 1'b0, reg_re = 1'b0, zp = 1'b0, pp = 1'b0;
  logic [7:0] reg_addr = 8'h0, node;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, disp, rv;
  logic [23:0] raw = 24'h0, adc_data;
  logic sample_req, adc_valid, rz_n, rp_n, ao_cur, exc, dstb, pk;
  logic [1:0] relay, link;
  logic [15:0] ao, haddr, hhi, hlo;
  logic [2:0] dp, baud;
  logic [3:0] unit;
  int error_cnt = 0, checked = 0, cyc = 0;

  initial forever #10 clk = ~clk;

  sia_sensor_model i_sensor (.clk(clk), .reset(reset), .sample_req(sample_req), .raw(raw), .zero_press(zp),
    .peak_press(pp), .adc_valid(adc_valid), .adc_data(adc_data), .remote_zero_n(rz_n), .remote_peak_n(rp_n));

  // Short counts keep debounce and sample periods to a few cycles
  sia_core #(.MS_CYC(10), .DEB_CYC(4)) i_dut (.clk(clk), .reset(reset), .clk_en(1'b1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .sample_req(sample_req),
    .adc_valid(adc_valid), .adc_data(adc_data), .remote_zero_n(rz_n), .remote_peak_n(rp_n), .relay_on(relay),
    .ao_value(ao), .ao_is_current(ao_cur), .exc_10v(exc), .display_value(disp), .display_strobe(dstb),
    .display_dp(dp), .display_unit(unit), .peak_active(pk), .hold_reg_addr(haddr), .hold_reg_hi(hhi),
    .hold_reg_lo(hlo), .node_id(node), .link_type(link), .baud_sel(baud));

  task automatic print_verdict;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk);
    reg_we <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk);
    reg_re <= 1'b0;
    #1 rv = reg_rdata;
    @(posedge clk);
  endtask

  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(n, rv, e);
  endtask

  // Several sample periods let a new raw value reach every output
  task automatic put(input logic [23:0] r);
    raw <= r;
    repeat (40) @(posedge clk);
  endtask

  task automatic ao_case(input logic [31:0] c, input logic [31:0] lo, input logic [31:0] hi,
      input logic [15:0] e0, input logic [15:0] e1);
    wr(OFS_CTRL, c);
    wr(OFS_AO_MIN, lo);
    wr(OFS_AO_MAX, hi);
    wr(OFS_CMD, 32'h10);
    for (int i = 0; i < 100; i++) begin
      rd(OFS_STATUS);
      if (rv[5] === 1'b0) break;
    end
    chk("busy", rv[5], 32'h0);
    put(lo[23:0]);
    chk("ao_low", ao, e0);
    put(hi[23:0]);
    chk("ao_high", ao, e1);
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict;
    end
  end

  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    put(24'h64);
    rchk("value", OFS_VALUE, 32'h64);
    chk("hold_addr", haddr, 32'h9c41);
    chk("hold_word", {hhi, hlo}, 32'h64);
    wr(OFS_ALM_BASE, 32'h5);
    wr(8'h24, 32'h32);
    wr(8'h28, 32'h96);
    wr(8'h2c, 32'h7);
    wr(8'h30, 32'h32);
    put(24'h64);
    chk("relay", relay, 32'h1);
    put(24'h14);
    chk("relay", relay, 32'h2);
    wr(8'h2c, 32'h2);
    wr(8'h34, 32'h96);
    put(24'hc8);
    chk("relay", relay, 32'h0);
    put(24'h64);
    chk("relay", relay, 32'h3);
    ao_case(32'h408, 32'ha, 32'h3c, 16'h0, 16'h2710);
    chk("exc", exc, 32'h1);
    ao_case(32'h1000, 32'h0, 32'hc8, 16'h0fa0, 16'h4e20);
    chk("ao_kind", ao_cur, 32'h1);
    wr(OFS_MULT, 32'h200);
    put(24'h64);
    rchk("value", OFS_VALUE, 32'hc8);
    wr(OFS_MULT, 32'h100);
    wr(OFS_COMM, 32'h1e5a);
    chk("node", node, 32'h0);
    wr(OFS_CMD, 32'h20);
    chk("comm", {node, link, baud}, {8'h5a, 2'h2, 3'h7});
    put(24'h12c);
    wr(OFS_CMD, 32'h4);
    rchk("tare", OFS_VALUE, 32'h0);
    put(24'h15e);
    zp <= 1'b1;
    repeat (30) @(posedge clk);
    zp <= 1'b0;
    put(24'h15e);
    rchk("remote_tare", OFS_VALUE, 32'h0);
    put(24'h190);
    rchk("value", OFS_VALUE, 32'h32);
    pp <= 1'b1;
    put(24'h1f4);
    put(24'h1c2);
    chk("peak_on", pk, 32'h1);
    rchk("peak", OFS_PEAK, 32'h96);
    chk("disp", disp, 32'h96);
    pp <= 1'b0;
    put(24'h1c2);
    chk("peak_on", pk, 32'h0);
    chk("disp", disp, 32'h64);
    put(24'h10);
    wr(OFS_CMD, 32'h1);
    rchk("zero_ref", OFS_ZERO, 32'h10);
    rchk("unmapped", 8'hfc, 32'h0);
    put(24'h74);
    wr(OFS_KNOWN, 32'hc8);
    wr(OFS_CMD, 32'h2);
    repeat (80) @(posedge clk);
    rchk("span_gain", OFS_GAIN, 32'h20000);
    wr(OFS_SENS, 32'h2);
    wr(OFS_FSCALE, 32'h1);
    wr(OFS_CMD, 32'h8);
    repeat (80) @(posedge clk);
    rchk("sens_value", OFS_VALUE, 32'hffffff06);
    wr(OFS_CTRL, 32'h15a006);
    put(24'h74);
    chk("ctrl_out", {pk, dp, unit}, {1'b1, 3'h5, 4'h5});
    rchk("torque", OFS_VALUE, 32'hfffffe3e);
    rchk("peak_sw", OFS_PEAK, 32'hffffff06);
    print_verdict;
  end
endmodule // testbench
